// ---- core/awt_exec.sv ----
// awt_exec: decode and execute of the trapping and plain word add
// assumes: register file supplies operands combinationally by index,
// and takes the write port one cycle after the instruction is issued
`timescale 1ns/1ps
module awt_exec
    import awt_pkg::*;
(
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    // instruction issue
    input  wire logic                 instr_valid,
    input  wire logic [WORD_W-1:0]    instr,
    // register file read
    output logic [REG_IDX_W-1:0]      rd_idx_a,
    output logic [REG_IDX_W-1:0]      rd_idx_b,
    input  wire logic [WORD_W-1:0]    rd_data_a,
    input  wire logic [WORD_W-1:0]    rd_data_b,
    // register file write
    output logic                      wr_en,
    output logic [REG_IDX_W-1:0]      wr_idx,
    output logic [WORD_W-1:0]         wr_data,
    // exception
    output logic                      ovf_exc
);
    awt_dec_if dec_bus ();

    logic                 wr_en_q, wr_en_d;
    logic [REG_IDX_W-1:0] wr_idx_q, wr_idx_d;
    logic [WORD_W-1:0]    wr_data_q, wr_data_d;
    logic                 ovf_q, ovf_d;
    logic [WORD_W:0]      sum_ext;
    logic                 ovf_hit;

    awt_decoder u_dec (
        .instr (instr),
        .dec   (dec_bus.dec)
    );

    // operand read indices track the current instruction; they stay
    // combinational because operands must return in the issue cycle
    assign rd_idx_a = dec_bus.src_a;
    assign rd_idx_b = dec_bus.src_b;

    // sign-extended add and overflow test on bits 32 and 31
    always_comb begin
        sum_ext = {rd_data_a[WORD_W-1], rd_data_a}
                + {rd_data_b[WORD_W-1], rd_data_b};
        ovf_hit = sum_ext[WORD_W] != sum_ext[WORD_W-1];
    end

    // next state of the write port and exception pulse
    always_comb begin
        wr_en_d    = 1'b0;
        wr_idx_d   = wr_idx_q;
        wr_data_d  = wr_data_q;
        ovf_d      = 1'b0;
        if (instr_valid) begin
            case (dec_bus.op)
                AWT_OP_ADD_TRAP: begin
                    if (ovf_hit) begin
                        ovf_d = 1'b1;
                    end else begin
                        wr_en_d   = 1'b1;
                        wr_idx_d  = dec_bus.dest;
                        wr_data_d = sum_ext[WORD_W-1:0];
                    end
                end
                AWT_OP_ADD_NOTRAP: begin
                    wr_en_d   = 1'b1;
                    wr_idx_d  = dec_bus.dest;
                    wr_data_d = sum_ext[WORD_W-1:0];
                end
                default: begin
                    wr_en_d = 1'b0;
                end
            endcase
        end
    end

    // register stage
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_en_q    <= 1'b0;
            wr_idx_q   <= RESET_IDX;
            wr_data_q  <= RESET_WORD;
            ovf_q      <= 1'b0;
        end else begin
            wr_en_q    <= wr_en_d;
            wr_idx_q   <= wr_idx_d;
            wr_data_q  <= wr_data_d;
            ovf_q      <= ovf_d;
        end
    end

    assign wr_en   = wr_en_q;
    assign wr_idx  = wr_idx_q;
    assign wr_data = wr_data_q;
    assign ovf_exc = ovf_q;
endmodule : awt_exec

// ---- core/awt_pkg.sv ----
// awt_pkg: field layout, opcode constants and widths for the word adder
// assumes: shared by the execute unit and its decode interface
package awt_pkg;
    localparam int          WORD_W       = 32;
    localparam int          REG_IDX_W    = 5;
    localparam int          OPC_HI       = 31;
    localparam int          OPC_LO       = 26;
    localparam int          SRCA_HI      = 25;
    localparam int          SRCA_LO      = 21;
    localparam int          SRCB_HI      = 20;
    localparam int          SRCB_LO      = 16;
    localparam int          DEST_HI      = 15;
    localparam int          DEST_LO      = 11;
    localparam int          ZERO_HI      = 10;
    localparam int          ZERO_LO      = 6;
    localparam int          FUNC_HI      = 5;
    localparam int          FUNC_LO      = 0;
    localparam logic [5:0]  OPC_SPECIAL  = 6'h00;
    localparam logic [4:0]  ZERO_FIELD   = 5'h00;
    localparam logic [5:0]  FUNC_ADD     = 6'h20;
    localparam logic [5:0]  FUNC_ADD_NT  = 6'h21;
    localparam logic [31:0] RESET_WORD   = 32'h0000_0000;
    localparam logic [4:0]  RESET_IDX    = 5'h00;

    // decoded operation class
    typedef enum logic [1:0] {
        AWT_OP_NONE,
        AWT_OP_ADD_TRAP,
        AWT_OP_ADD_NOTRAP
    } awt_op_t;
endpackage : awt_pkg

// ---- core/awt_dec_if.sv ----
// awt_dec_if: decoded fields handed from decoder to execute stage
// assumes: both ends run on ref_clk in the same module
`timescale 1ns/1ps
interface awt_dec_if;
    import awt_pkg::*;
    logic [REG_IDX_W-1:0] src_a;
    logic [REG_IDX_W-1:0] src_b;
    logic [REG_IDX_W-1:0] dest;
    awt_op_t              op;
    modport dec (output src_a, output src_b, output dest, output op);
    modport exe (input src_a, input src_b, input dest, input op);
endinterface : awt_dec_if

// ---- core/awt_decoder.sv ----
// awt_decoder: splits an instruction word and classifies the add forms
// assumes: instruction word is stable from same-clock fetch logic
`timescale 1ns/1ps
module awt_decoder
    import awt_pkg::*;
(
    // instruction in
    input  wire logic [WORD_W-1:0] instr,
    // decoded fields out
    awt_dec_if.dec                 dec
);
    // field split and opcode match
    always_comb begin
        dec.src_a = instr[SRCA_HI:SRCA_LO];
        dec.src_b = instr[SRCB_HI:SRCB_LO];
        dec.dest  = instr[DEST_HI:DEST_LO];
        dec.op    = AWT_OP_NONE;
        // non-zero spare field is treated as no operation
        if (instr[OPC_HI:OPC_LO] == OPC_SPECIAL &&
            instr[ZERO_HI:ZERO_LO] == ZERO_FIELD) begin
            if (instr[FUNC_HI:FUNC_LO] == FUNC_ADD) begin
                dec.op = AWT_OP_ADD_TRAP;
            end else if (instr[FUNC_HI:FUNC_LO] == FUNC_ADD_NT) begin
                dec.op = AWT_OP_ADD_NOTRAP;
            end
        end
    end
endmodule : awt_decoder

// ---- dv/awt_exec_sva.sv ----
// awt_exec_sva: port checks on the word adder
// assumes: bound to awt_exec, one ref_clk domain
`timescale 1ns/1ps
module awt_exec_sva (
    input wire logic        ref_clk, rst_n, instr_valid, wr_en, ovf_exc,
    input wire logic [31:0] instr, rd_data_a, rd_data_b, wr_data,
    input wire logic [4:0]  rd_idx_a, rd_idx_b, wr_idx
);
    logic [32:0] s;
    logic        ok, at, an;
    // sign-extended sum and the two accepted forms
    assign s  = {rd_data_a[31], rd_data_a} + {rd_data_b[31], rd_data_b};
    assign ok = instr_valid && instr[31:26] == 6'h00 && instr[10:6] == 5'h00;
    assign at = ok && instr[5:0] == 6'h20;
    assign an = ok && instr[5:0] == 6'h21;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    chk_src_index: assert property (
        rd_idx_a == instr[25:21] && rd_idx_b == instr[20:16])
        else $error("source index wrong");
    chk_trap_ovf: assert property (
        at && s[32] != s[31] |=> ovf_exc && !wr_en) else $error("no trap");
    chk_trap_write: assert property (
        at && s[32] == s[31] |=> wr_en && !ovf_exc &&
        wr_data == $past(s[31:0]) && wr_idx == $past(instr[15:11]))
        else $error("bad write");
    chk_plain_write: assert property (
        an |=> wr_en && !ovf_exc && wr_data == $past(s[31:0]))
        else $error("bad plain write");
    chk_refused_op: assert property (
        instr_valid && !at && !an |=> !wr_en && !ovf_exc)
        else $error("refused word acted");
    chk_pulse_cause: assert property (
        wr_en || ovf_exc |-> $past(at || an)) else $error("stray pulse");
    chk_data_hold: assert property (
        !wr_en |-> $stable(wr_data) && $stable(wr_idx))
        else $error("result moved");
endmodule : awt_exec_sva

// ---- dv/tb_add_word_trap_on_overflow.sv ----
// tb_add_word_trap_on_overflow: directed tests of the word adder
// assumes: awt_exec alone, operands driven straight by the bench
`timescale 1ns/1ps
module tb_add_word_trap_on_overflow;
    logic        ref_clk = 1'b0, rst_n = 1'b0, instr_valid = 1'b0;
    logic [31:0] instr = 32'h0, rd_data_a = 32'h0, rd_data_b = 32'h0;
    logic [31:0] wr_data;
    logic [4:0]  rd_idx_a, rd_idx_b, wr_idx;
    logic        wr_en, ovf_exc;
    int          n_errors = 0, cmp_count = 0, cyc = 0;
    // largest positive and most negative words
    localparam logic [31:0] MAXP = 32'h7FFFFFFF, MINN = 32'h80000000;
    awt_exec i_dut (.ref_clk, .rst_n, .instr_valid, .instr, .rd_idx_a,
        .rd_idx_b, .rd_data_a, .rd_data_b, .wr_en, .wr_idx, .wr_data,
        .ovf_exc);
    // clock and hang ceiling
    initial forever #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 500) begin
            n_errors++;
            stop_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // issue one word, judge the pulse one edge later
    task automatic op(input logic [5:0] o, input logic [4:0] z,
        input logic [5:0] f, input logic [31:0] a, input logic [31:0] b,
        input logic w, input logic e, input logic [31:0] d);
        instr = {o, 5'h03, 5'h1C, 5'h0B, z, f};
        rd_data_a = a;
        rd_data_b = b;
        instr_valid = 1'b1;
        #1 chk(32'({rd_idx_b, rd_idx_a}), 32'h383);
        @(posedge ref_clk);
        #1 chk(32'({wr_en, ovf_exc}), 32'({w, e}));
        chk(wr_data, d);
        chk(32'(wr_idx), 32'h0B);
    endtask : op
    task automatic idle(input string nm);
        instr_valid = 1'b0;
        @(posedge ref_clk);
        #1 $display("done %s", nm);
    endtask : idle
    // trapping add: plain sums and both overflow signs back to back
    task automatic t_trap();
        op(6'h00, 5'h00, 6'h20, 32'h5, 32'h7, 1, 0, 32'hC);
        op(6'h00, 5'h00, 6'h20, MAXP, 32'h1, 0, 1, 32'hC);
        op(6'h00, 5'h00, 6'h20, MINN, -1, 0, 1, 32'hC);
        op(6'h00, 5'h00, 6'h20, -1, -1, 1, 0, 32'hFFFFFFFE);
        idle("trap");
    endtask : t_trap
    // plain add writes even when the signed sum wraps
    task automatic t_plain();
        op(6'h00, 5'h00, 6'h21, MAXP, 1, 1, 0, MINN);
        op(6'h00, 5'h00, 6'h21, MINN, MINN, 1, 0, 0);
        idle("plain");
    endtask : t_plain
    // spare bits, other opcode, other function: nothing happens
    task automatic t_refuse();
        op(6'h00, 5'h01, 6'h20, 1, 1, 0, 0, 0);
        op(6'h01, 5'h00, 6'h20, 1, 1, 0, 0, 0);
        op(6'h00, 5'h00, 6'h22, 1, 1, 0, 0, 0);
        idle("refuse");
    endtask : t_refuse
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    initial begin
        repeat (16) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        t_trap();
        t_plain();
        t_refuse();
        stop_test();
    end
endmodule : tb_add_word_trap_on_overflow
bind awt_exec awt_exec_sva i_sva (.ref_clk, .rst_n, .instr_valid, .wr_en,
    .ovf_exc, .instr, .rd_data_a, .rd_data_b, .wr_data, .rd_idx_a,
    .rd_idx_b, .wr_idx);
